// ### core/dcs_defines.svh
// Constants for the DMA channel status and count block: offsets, fields, resets.
// Assumes inclusion by bare name from the package and the top module.
`ifndef DCS_DEFINES_SVH
`define DCS_DEFINES_SVH
// ==========================================================================
// Geometry
`define DCS_NCH            8
`define DCS_ADDR_W         8
`define DCS_CNT_W          10
// ==========================================================================
// Register byte offsets (per-channel pair at base + ch*8)
`define DCS_PAD_OFF        8'h00
`define DCS_CNT_OFF        8'h04
`define DCS_CS0_OFF        8'h40
`define DCS_CS1_OFF        8'h44
`define DCS_ADR_OFF        8'h48
`define DCS_IST_OFF        8'h4c
`define DCS_IMSK_OFF       8'h50
// ==========================================================================
// Reset values
`define DCS_PAD_RST        16'h0000
`define DCS_CNT_RST        10'h000
`define DCS_LAST_ACTIVE_CHANNEL_RST      4'hf
`define DCS_ADR_RST        16'h0000
// ==========================================================================
// Field positions
`define DCS_PCOL_LSB       8
`define DCS_LAST_ACTIVE_CHANNEL_LSB      8
`define DCS_MODE_PP_BIT    1
`define DCS_IRQ_PCOL_BIT   8
`define DCS_IRQ_XCOL_BIT   9
`define DCS_IRQ_W          10
// ==========================================================================
// AXI responses
`define DCS_RESP_OKAY      2'b00
`define DCS_RESP_DECERR    2'b11
`endif

// ### core/dcs_pkg.sv
// Types for the DMA channel status and count block.
// Assumes dcs_defines.svh is on the include path.
`include "dcs_defines.svh"
package dcs_pkg;
  // ========================================================================
  // Register decode
  typedef enum logic [7:0] {
    DCS_SEL_NONE = 8'h01,
    DCS_SEL_PAD  = 8'h02,
    DCS_SEL_CNT  = 8'h04,
    DCS_SEL_CS0  = 8'h08,
    DCS_SEL_CS1  = 8'h10,
    DCS_SEL_ADR  = 8'h20,
    DCS_SEL_IST  = 8'h40,
    DCS_SEL_IMSK = 8'h80
  } dcs_sel_e;
  typedef struct packed {
    dcs_sel_e   kind;
    logic [2:0] ch;
  } dcs_dec_s;
endpackage : dcs_pkg

// ### core/dcs_top.sv
// Per-channel peripheral address and count registers plus controller status
// for an eight-channel DMA controller, behind an AXI4-Lite slave.
// Assumes transfer-path inputs come from logic on aclk (no synchronisers).
//
// Register access over AXI4-Lite and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "dcs_defines.svh"
module dcs_top (
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  // AXI4-Lite slave
  input  wire logic [`DCS_ADDR_W-1:0]        awaddr,
  input  wire logic                          awvalid,
  output logic                               awready,
  input  wire logic [31:0]                   wdata,
  input  wire logic [3:0]                    wstrb,
  input  wire logic                          wvalid,
  output logic                               wready,
  output logic [1:0]                         bresp,
  output logic                               bvalid,
  input  wire logic                          bready,
  input  wire logic [`DCS_ADDR_W-1:0]        araddr,
  input  wire logic                          arvalid,
  output logic                               arready,
  output logic [31:0]                        rdata,
  output logic [1:0]                         rresp,
  output logic                               rvalid,
  input  wire logic                          rready,
  // Channel control from the control registers
  input  wire logic [`DCS_NCH-1:0]           channel_enable,
  input  wire logic [2*`DCS_NCH-1:0]         channel_mode,
  input  wire logic [16*`DCS_NCH-1:0]        primary_start_offset,
  input  wire logic [16*`DCS_NCH-1:0]        secondary_start_offset,
  // Transfer path events
  input  wire logic                          xfer_strobe,
  input  wire logic [2:0]                    xfer_channel,
  input  wire logic [15:0]                   xfer_ram_addr,
  input  wire logic [`DCS_NCH-1:0]           block_done,
  input  wire logic [`DCS_NCH-1:0]           periph_collision,
  input  wire logic [`DCS_NCH-1:0]           ram_collision,
  // To the transfer path
  output logic [16*`DCS_NCH-1:0]             channel_peripheral_address,
  output logic [`DCS_CNT_W*`DCS_NCH-1:0]     xfer_count,
  output logic [(`DCS_CNT_W+1)*`DCS_NCH-1:0] block_length,
  output logic [16*`DCS_NCH-1:0]             active_start_offset,
  output logic [`DCS_NCH-1:0]                pingpong_select_status,
  output logic                               irq
);
  import dcs_pkg::*;

  // ========================================================================
  // Decode
  // Shared by both channels of the bus so reads and writes agree on the map
  function automatic dcs_dec_s dcs_decode(input logic [`DCS_ADDR_W-1:0] a);
    dcs_dec_s d;
    d.kind = DCS_SEL_NONE;
    d.ch   = a[5:3];
    if (a[1:0] != 2'b00) begin
      d.kind = DCS_SEL_NONE;
    end else if (a[7:6] == 2'b00) begin
      d.kind = a[2] ? DCS_SEL_CNT : DCS_SEL_PAD;
    end else begin
      case (a)
        `DCS_CS0_OFF:  d.kind = DCS_SEL_CS0;
        `DCS_CS1_OFF:  d.kind = DCS_SEL_CS1;
        `DCS_ADR_OFF:  d.kind = DCS_SEL_ADR;
        `DCS_IST_OFF:  d.kind = DCS_SEL_IST;
        `DCS_IMSK_OFF: d.kind = DCS_SEL_IMSK;
        default:       d.kind = DCS_SEL_NONE;
      endcase
    end
    return d;
  endfunction : dcs_decode

  // Byte-lane merge over the low half-word; upper lanes hold nothing
  function automatic logic [15:0] dcs_merge(input logic [15:0] old_v,
                                            input logic [31:0] wd,
                                            input logic [3:0]  st);
    logic [15:0] m;
    m = old_v;
    if (st[0]) m[7:0]  = wd[7:0];
    if (st[1]) m[15:8] = wd[15:8];
    return m;
  endfunction : dcs_merge

  // ========================================================================
  // State
  logic [15:0]             pad_ff [`DCS_NCH];
  logic [`DCS_CNT_W-1:0]   cnt_ff [`DCS_NCH];
  logic [`DCS_CNT_W:0]     blk_len_ff [`DCS_NCH];
  logic [15:0]             start_ff [`DCS_NCH];
  logic [`DCS_NCH-1:0]     pcol_ff;
  logic [`DCS_NCH-1:0]     xcol_ff;
  logic [3:0]              last_active_channel_ff;
  logic [`DCS_NCH-1:0]     pp_ff;
  logic [15:0]             ram_adr_ff;
  logic [`DCS_IRQ_W-1:0]   ist_ff;
  logic [`DCS_IRQ_W-1:0]   imsk_ff;
  logic                    aw_held_ff;
  logic                    w_held_ff;
  logic [`DCS_ADDR_W-1:0]  awaddr_ff;
  logic [31:0]             wdata_ff;
  logic [3:0]              wstrb_ff;
  logic                    bvalid_ff;
  logic [1:0]              bresp_ff;
  logic                    rvalid_ff;
  logic [1:0]              rresp_ff;
  logic [31:0]             rdata_ff;
  logic                    do_write;
  logic                    do_read;
  dcs_dec_s                wdec;
  dcs_dec_s                rdec;
  logic [31:0]             nxt_rdata;
  logic [`DCS_NCH-1:0]     nxt_pcol;
  logic [`DCS_NCH-1:0]     nxt_xcol;
  logic [`DCS_NCH-1:0]     pp_toggle;
  logic [15:0]             imsk_wr;

  // ========================================================================
  // AXI4-Lite handshakes
  // One write at a time: address and data are parked until the response leaves
  assign awready  = !aw_held_ff && !bvalid_ff;
  assign wready   = !w_held_ff && !bvalid_ff;
  assign arready  = !rvalid_ff;
  assign bvalid   = bvalid_ff;
  assign bresp    = bresp_ff;
  assign rvalid   = rvalid_ff;
  assign rresp    = rresp_ff;
  assign rdata    = rdata_ff;
  assign do_write = aw_held_ff && w_held_ff && !bvalid_ff;
  assign do_read  = arvalid && arready;
  assign wdec     = dcs_decode(awaddr_ff);
  assign rdec     = dcs_decode(araddr);

  // Write address and data capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      awaddr_ff  <= '0;
      wdata_ff   <= 32'h0000_0000;
      wstrb_ff   <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_held_ff <= 1'b1;
        awaddr_ff  <= awaddr;
      end else if (do_write) begin
        aw_held_ff <= 1'b0;
      end
      if (wvalid && wready) begin
        w_held_ff <= 1'b1;
        wdata_ff  <= wdata;
        wstrb_ff  <= wstrb;
      end else if (do_write) begin
        w_held_ff <= 1'b0;
      end
    end
  end

  // Write response; read-only registers accept and ignore writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= `DCS_RESP_OKAY;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= (wdec.kind == DCS_SEL_NONE) ? `DCS_RESP_DECERR : `DCS_RESP_OKAY;
    end else if (bvalid_ff && bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // Read data mux
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    case (rdec.kind)
      DCS_SEL_PAD:  nxt_rdata[15:0] = pad_ff[rdec.ch];
      DCS_SEL_CNT:  nxt_rdata[`DCS_CNT_W-1:0] = cnt_ff[rdec.ch];
      DCS_SEL_CS0:  nxt_rdata[15:0] = {pcol_ff, xcol_ff};
      DCS_SEL_CS1:  nxt_rdata[15:0] = {4'h0, last_active_channel_ff, pp_ff};
      DCS_SEL_ADR:  nxt_rdata[15:0] = ram_adr_ff;
      DCS_SEL_IST:  nxt_rdata[`DCS_IRQ_W-1:0] = ist_ff;
      DCS_SEL_IMSK: nxt_rdata[`DCS_IRQ_W-1:0] = imsk_ff;
      default:      nxt_rdata = 32'h0000_0000;
    endcase
  end

  // Read response, one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rresp_ff  <= `DCS_RESP_OKAY;
      rdata_ff  <= 32'h0000_0000;
    end else if (do_read) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= nxt_rdata;
      rresp_ff  <= (rdec.kind == DCS_SEL_NONE) ? `DCS_RESP_DECERR : `DCS_RESP_OKAY;
    end else if (rvalid_ff && rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // ========================================================================
  // Per-channel registers
  genvar gi;
  generate
    for (gi = 0; gi < `DCS_NCH; gi++) begin : g_ch
      // Writes while enabled are still taken; keeping off them is software's job
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          pad_ff[gi] <= `DCS_PAD_RST;
        end else if (do_write && wdec.kind == DCS_SEL_PAD && wdec.ch == 3'(gi)) begin
          pad_ff[gi] <= dcs_merge(pad_ff[gi], wdata_ff, wstrb_ff);
        end
      end

      // Count and the derived block length (count plus one)
      logic [15:0] cnt_wr;
      assign cnt_wr = dcs_merge({6'h00, cnt_ff[gi]}, wdata_ff, wstrb_ff);
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          cnt_ff[gi]     <= `DCS_CNT_RST;
          blk_len_ff[gi] <= {1'b0, `DCS_CNT_RST} + 11'h001;
        end else if (do_write && wdec.kind == DCS_SEL_CNT && wdec.ch == 3'(gi)) begin
          cnt_ff[gi]     <= cnt_wr[`DCS_CNT_W-1:0];
          blk_len_ff[gi] <= {1'b0, cnt_wr[`DCS_CNT_W-1:0]} + 11'h001;
        end
      end

      // Start offset in use follows the ping-pong bit
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          start_ff[gi] <= 16'h0000;
        end else begin
          start_ff[gi] <= pp_ff[gi] ? secondary_start_offset[gi*16 +: 16]
                                    : primary_start_offset[gi*16 +: 16];
        end
      end

      // Toggle only on an enabled channel in a ping-pong mode
      assign pp_toggle[gi] = block_done[gi] && channel_enable[gi]
                          && channel_mode[gi*2+`DCS_MODE_PP_BIT];

      assign channel_peripheral_address[gi*16 +: 16]               = pad_ff[gi];
      assign xfer_count[gi*`DCS_CNT_W +: `DCS_CNT_W]               = cnt_ff[gi];
      assign block_length[gi*(`DCS_CNT_W+1) +: (`DCS_CNT_W+1)]     = blk_len_ff[gi];
      assign active_start_offset[gi*16 +: 16]                      = start_ff[gi];
    end
  endgenerate

  // ========================================================================
  // Controller status
  // Clear-only flags: a written zero clears; a new collision in that cycle wins
  always_comb begin
    nxt_pcol = pcol_ff;
    nxt_xcol = xcol_ff;
    if (do_write && wdec.kind == DCS_SEL_CS0) begin
      if (wstrb_ff[1]) nxt_pcol = pcol_ff & wdata_ff[15:8];
      if (wstrb_ff[0]) nxt_xcol = xcol_ff & wdata_ff[7:0];
    end
    nxt_pcol = nxt_pcol | periph_collision;
    nxt_xcol = nxt_xcol | ram_collision;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pcol_ff <= '0;
      xcol_ff <= '0;
    end else begin
      pcol_ff <= nxt_pcol;
      xcol_ff <= nxt_xcol;
    end
  end

  // Last channel and last RAM address track every transfer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_active_channel_ff   <= `DCS_LAST_ACTIVE_CHANNEL_RST;
      ram_adr_ff <= `DCS_ADR_RST;
    end else if (xfer_strobe) begin
      last_active_channel_ff   <= {1'b0, xfer_channel};
      ram_adr_ff <= xfer_ram_addr;
    end
  end

  // Ping-pong select; one-shot ping-pong stop is left to the control logic
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pp_ff <= '0;
    end else begin
      pp_ff <= pp_ff ^ pp_toggle;
    end
  end
  assign pingpong_select_status = pp_ff;

  // ========================================================================
  // Interrupts
  // Read of the status clears it, but an event in the same cycle survives
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ist_ff <= '0;
    end else begin
      ist_ff <= ((do_read && rdec.kind == DCS_SEL_IST) ? '0 : ist_ff)
              | {|ram_collision, |periph_collision, block_done};
    end
  end

  // Mask write keeps only the implemented status bits
  assign imsk_wr = dcs_merge({6'h00, imsk_ff}, wdata_ff, wstrb_ff);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      imsk_ff <= '0;
    end else if (do_write && wdec.kind == DCS_SEL_IMSK) begin
      imsk_ff <= imsk_wr[`DCS_IRQ_W-1:0];
    end
  end

  assign irq = |(ist_ff & imsk_ff);

endmodule : dcs_top

// ### test/dcs_top_sva.sv
// Checker for the DMA status and count block, watching top-level ports.
// Assumes it is bound into dcs_top and runs on aclk.
`timescale 1ns/1ps
module dcs_top_sva (
  input wire logic         aclk,
  input wire logic         aresetn,
  input wire logic         awvalid,
  input wire logic         awready,
  input wire logic         wvalid,
  input wire logic         wready,
  input wire logic         bvalid,
  input wire logic         arvalid,
  input wire logic         arready,
  input wire logic         rvalid,
  input wire logic         rready,
  input wire logic [31:0]  rdata,
  input wire logic [7:0]   channel_enable,
  input wire logic [15:0]  channel_mode,
  input wire logic [127:0] primary_start_offset,
  input wire logic [127:0] secondary_start_offset,
  input wire logic [7:0]   block_done,
  input wire logic [127:0] channel_peripheral_address,
  input wire logic [79:0]  xfer_count,
  input wire logic [87:0]  block_length,
  input wire logic [127:0] active_start_offset,
  input wire logic [7:0]   pingpong_select_status
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // Bus handshakes
  sequence s_wr_pair;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_rd_take;
    arvalid && arready;
  endsequence
  sequence s_pp_block;
    block_done[2] && channel_enable[2] && channel_mode[5];
  endsequence
  // Both halves parked at the taking edge, response raised on the edge after
  a_wr_answer: assert property (s_wr_pair |=> ##1 bvalid) else $error("write not answered");
  a_rd_answer: assert property (s_rd_take |=> rvalid) else $error("read not answered");
  a_rd_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  a_rd_refuse: assert property (rvalid |-> !arready) else $error("read taken while busy");
  // ==========================================================
  // Channel state; block length must track count plus one at all times
  a_len_count: assert property (block_length[10:0] == {1'b0, xfer_count[9:0]} + 11'h1)
    else $error("block length not count plus one");
  a_pad_reset: assert property ($rose(aresetn) |-> channel_peripheral_address == '0
    && pingpong_select_status == '0) else $error("reset value wrong");
  a_pp_toggle: assert property (s_pp_block |=> pingpong_select_status[2]
    != $past(pingpong_select_status[2])) else $error("ping-pong bit not toggled");
  a_pp_steady: assert property (!(block_done[2] && channel_enable[2] && channel_mode[5])
    |=> $stable(pingpong_select_status[2])) else $error("ping-pong bit moved");
  // Offset settles one cycle after select or inputs change
  a_start_pick: assert property ($past(aresetn) && $stable(pingpong_select_status[2])
    && $stable(primary_start_offset[47:32]) && $stable(secondary_start_offset[47:32])
    |-> active_start_offset[47:32] == (pingpong_select_status[2] ?
    secondary_start_offset[47:32] : primary_start_offset[47:32])) else $error("wrong start");
endmodule : dcs_top_sva

bind dcs_top dcs_top_sva u_sva (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready,
  .bvalid, .arvalid, .arready, .rvalid, .rready, .rdata, .channel_enable, .channel_mode,
  .primary_start_offset, .secondary_start_offset, .block_done, .channel_peripheral_address,
  .xfer_count, .block_length, .active_start_offset, .pingpong_select_status);

// ### test/dcs_far_model.sv
// Transfer path model: raises transfer, block end and collision pulses.
// Assumes the caller waits for the task to return before the next event.
`timescale 1ns/1ps
module dcs_far_model (
  input wire logic aclk,
  output logic        xfer_strobe,
  output logic [2:0]  xfer_channel,
  output logic [15:0] xfer_ram_addr,
  output logic [7:0]  block_done,
  output logic [7:0]  periph_collision,
  output logic [7:0]  ram_collision
);
  // Idle state at time zero
  initial begin
    xfer_strobe = 1'b0;
    xfer_channel = 3'h0;
    xfer_ram_addr = 16'h0;
    block_done = 8'h00;
    periph_collision = 8'h00;
    ram_collision = 8'h00;
  end
  // One-cycle event: 0 transfer, 1 block end, 2 peripheral and 3 RAM collision
  task automatic ev(input int k, input logic [2:0] c, input logic [15:0] a);
    @(posedge aclk);
    xfer_strobe <= (k == 0);
    xfer_channel <= c;
    xfer_ram_addr <= a;
    block_done <= (k == 1) ? 8'h01 << c : 8'h00;
    periph_collision <= (k == 2) ? 8'h01 << c : 8'h00;
    ram_collision <= (k == 3) ? 8'h01 << c : 8'h00;
    @(posedge aclk);
    xfer_strobe <= 1'b0;
    block_done <= 8'h00;
    periph_collision <= 8'h00;
    ram_collision <= 8'h00;
    // Invalid qualifiers show the inverse so a stale capture is caught
    xfer_channel <= ~c;
    xfer_ram_addr <= ~a;
  endtask : ev
endmodule : dcs_far_model

// ### test/test_dma_channel_status_and_count.sv
// Self-checking bench for the DMA status and count block.
// Assumes the checker is bound separately and the far model drives events.
`timescale 1ns/1ps
module test_dma_channel_status_and_count;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid, irq;
  logic xfer_strobe;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0, channel_enable = 8'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] bresp, rresp;
  logic [15:0] channel_mode = 16'h0, xfer_ram_addr;
  logic [2:0] xfer_channel;
  logic [127:0] primary_start_offset = 128'h0, secondary_start_offset = 128'h0;
  logic [7:0] block_done, periph_collision, ram_collision;
  logic [33:0] q[$];
  int errors = 0, n_checks = 0;
  // 40 MHz clock
  always #12.5 aclk = ~aclk;
  dcs_top uut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .channel_enable, .channel_mode, .primary_start_offset, .secondary_start_offset,
    .xfer_strobe, .xfer_channel, .xfer_ram_addr, .block_done, .periph_collision,
    .ram_collision, .channel_peripheral_address(), .xfer_count(), .block_length(),
    .active_start_offset(), .pingpong_select_status(), .irq);
  dcs_far_model far (.aclk, .xfer_strobe, .xfer_channel, .xfer_ram_addr, .block_done,
    .periph_collision, .ram_collision);
  // ==========================================================
  // Checking and closing
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude;
    $display("checks %0d, mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude
  // Responses are compared against the oldest note, half a cycle before the handshake
  always @(negedge aclk) begin
    if (bvalid && bready) chk({bresp, 32'h0}, q.pop_front());
    if (rvalid && rready) chk({rresp, rdata}, q.pop_front());
  end
  // ==========================================================
  // Bus master; the first edge lets the previous release land
  task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d,
                     input logic [33:0] e);
    logic pa, pw, pb, ta, tw, tb;
    int n;
    @(posedge aclk);
    q.push_back(e);
    pa = 1'b1;
    pw = !rd;
    pb = 1'b1;
    if (rd) begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
    end else begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
    end
    for (n = 0; pa || pw || pb; n++) begin
      if (n == 50) begin
        errors++;
        conclude();
      end
      @(negedge aclk);
      ta = pa && (rd ? arready : awready);
      tw = pw && wready;
      tb = pb && (rd ? rvalid : bvalid);
      @(posedge aclk);
      if (ta) begin
        pa = 1'b0;
        if (rd) arvalid <= 1'b0;
        else awvalid <= 1'b0;
      end
      if (tw) begin
        pw = 1'b0;
        wvalid <= 1'b0;
      end
      if (tb) begin
        pb = 1'b0;
        if (rd) rready <= 1'b0;
        else bready <= 1'b0;
      end
    end
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] v);
    bus(1'b1, a, 32'h0, {2'b00, v});
  endtask : rd
  task automatic ck_irq(input logic e);
    @(negedge aclk);
    chk({33'h0, irq}, {33'h0, e});
  endtask : ck_irq
  // ==========================================================
  // Main sequence; channels stay disabled while their registers are written
  initial begin
    int i, k;
    logic [31:0] d;
    logic [15:0] a;
    d = $urandom(32'h28ac);
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 8; i++) begin
      rd(8'(8 * i), 32'h0);
      rd(8'(8 * i + 4), 32'h0);
    end
    rd(8'h40, 32'h0);
    rd(8'h48, 32'h0);
    bus(1'b1, 8'h54, 32'h0, {2'b11, 32'h0});
    bus(1'b0, 8'h54, 32'h1, {2'b11, 32'h0});
    bus(1'b0, 8'h44, 32'hffff, 34'h0);
    rd(8'h44, 32'h0f00);
    $display("reset values done");
    for (i = 0; i < 8; i++) begin
      d = $urandom;
      bus(1'b0, 8'(8 * i), d, 34'h0);
      rd(8'(8 * i), {16'h0, d[15:0]});
      bus(1'b0, 8'(8 * i + 4), d, 34'h0);
      rd(8'(8 * i + 4), {22'h0, d[9:0]});
    end
    bus(1'b0, 8'h3c, 32'hffffffff, 34'h0);
    rd(8'h3c, 32'h3ff);
    $display("channel registers done");
    bus(1'b0, 8'h50, 32'h1, 34'h0);
    far.ev(1, 3'h0, 16'h0);
    ck_irq(1'b1);
    rd(8'h4c, 32'h1);
    ck_irq(1'b0);
    far.ev(2, 3'h7, 16'h0);
    far.ev(3, 3'h0, 16'h0);
    rd(8'h40, 32'h8001);
    ck_irq(1'b0);
    bus(1'b0, 8'h50, 32'h300, 34'h0);
    ck_irq(1'b1);
    rd(8'h4c, 32'h300);
    bus(1'b0, 8'h40, 32'h7fff, 34'h0);
    rd(8'h40, 32'h0001);
    bus(1'b0, 8'h40, 32'h0, 34'h0);
    rd(8'h40, 32'h0);
    $display("collisions and interrupt done");
    for (i = 5; i >= 0; i = i - 5) begin
      a = 16'($urandom);
      far.ev(0, 3'(i), a);
      rd(8'h44, 32'(i) << 8);
      rd(8'h48, {16'h0, a});
    end
    $display("transfer history done");
    primary_start_offset <= {4{$urandom}};
    secondary_start_offset <= {4{$urandom}};
    channel_mode <= 16'he4e4;
    channel_enable <= 8'hff;
    for (k = 0; k < 2; k++) begin
      for (i = 0; i < 8; i++) far.ev(1, 3'(i), 16'h0);
      rd(8'h44, (k == 0) ? 32'hcc : 32'h0);
    end
    $display("ping-pong done");
    conclude();
  end
endmodule : test_dma_channel_status_and_count
